//--- bench/see_link_asserts.sv
// Protocol assertions on the SPI link between host and device
module see_link_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic guard_n,
  input wire logic miso_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_q;
  logic [2:0] rise_cnt_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Rises within a frame modulo one byte; cleared while deselected
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rise_cnt_q <= 3'h0;
    end else if (cs_n) begin
      rise_cnt_q <= 3'h0;
    end else if (sclk && !sclk_q) begin
      rise_cnt_q <= rise_cnt_q + 3'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_frame_lead;
    (!sclk) [*4];
  endsequence

  property p_sclk_idle; cs_n |-> !sclk; endproperty
  property p_high_phase; $rose(sclk) |-> s_high_phase; endproperty
  property p_frame_lead; $fell(cs_n) |-> s_frame_lead; endproperty
  property p_mosi_hold; sclk && sclk_q |-> $stable(mosi); endproperty
  property p_miso_on_low; miso_oe && $changed(miso) |-> !sclk; endproperty
  property p_cs_rise_low; $rose(cs_n) |-> !sclk && !sclk_q; endproperty
  property p_whole_bytes; $rose(cs_n) |-> rise_cnt_q == 3'h0; endproperty
  property p_oe_released; cs_n [*4] |-> !miso_oe; endproperty
  property p_oe_opcode; $fell(cs_n) |-> (!miso_oe) [*8]; endproperty

  a_sclk_idle: assert property (p_sclk_idle) else $error("link clock not idle low");
  a_high_phase: assert property (p_high_phase) else $error("link clock high phase wrong");
  a_frame_lead: assert property (p_frame_lead) else $error("link clock early in frame");
  a_mosi_hold: assert property (p_mosi_hold) else $error("data in moved while clock high");
  a_miso_on_low: assert property (p_miso_on_low) else $error("data out moved while clock high");
  a_cs_rise_low: assert property (p_cs_rise_low) else $error("deselect not after last bit");
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame not whole bytes");
  a_oe_released: assert property (p_oe_released) else $error("data out driven unselected");
  a_oe_opcode: assert property (p_oe_opcode) else $error("data out driven during opcode");
endmodule // see_link_asserts

//--- bench/spi_eeprom_instruction_status_tb.sv
// Self-checking bench: host and device ends joined over the SPI link
module spi_eeprom_instruction_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import see_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [7:0] status_o;
  logic hw_lock_o, id_locked_o, write_start_o, refused_o;
  logic rd_d = 1'b0;
  logic guard_lvl = 1'b1;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'ha54f;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic ev_q[$];

  see_spi_if spi ();
  see_device #(.WRITE_CYCLES(400)) see_device_i (.clk_i(clk_i), .rst_i(rst_i), .spi(spi),
    .status_o(status_o), .hw_lock_o(hw_lock_o), .id_locked_o(id_locked_o),
    .write_start_o(write_start_o), .refused_o(refused_o));
  see_host see_host_i (.clk_i(clk_i), .rst_i(rst_i), .spi(spi), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  see_link_asserts see_link_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .sclk(spi.sclk),
    .cs_n(spi.cs_n), .mosi(spi.mosi), .miso(spi.miso), .miso_oe(spi.miso_oe),
    .guard_n(spi.guard_n), .miso_line(spi.miso_line));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] read data expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_event(input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] write start expected %b seen %b", e, g);
    end
  endtask

  task automatic chk_level(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] device level expected %h seen %h", e, g);
    end
  endtask

  // Results arrive one cycle after the read strobe; events as start or refuse pulses
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d && exp_q.size() > 0) begin
      if (msk_q[0] != 32'h0000_0000) chk_word(exp_q[0], rdata_o & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (write_start_o || refused_o) chk_event(ev_q.size() ? ev_q.pop_front() : 1'bx, write_start_o);
  end

  // A gap cycle after each strobe keeps every signal to one assignment per step
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic xfer(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
                      input logic [1:0] f, input logic [3:0] rlen);
    bus_wr(HR_OPCODE, {24'h00_0000, op});
    bus_wr(HR_ADDR, {16'h0000, a});
    bus_wr(HR_WDATA, {24'h00_0000, d});
    bus_wr(HR_CTRL, {24'h00_0000, rlen, guard_lvl, f, 1'b1});
    for (int n = 0; n < 2000; n++) begin
      bus_rd(HR_STATUS, 32'h0000_0000, 32'h0000_0000);
      if (rdata_o[0] === 1'b0) return;
    end
    bad_count++;
    conclude();
  endtask

  task automatic rdat(input logic [7:0] e);
    bus_rd(HR_RDATA, {24'h00_0000, e}, 32'h0000_00FF);
  endtask

  task automatic stat(input logic [7:0] e);
    xfer(OP_STAT_READ, 16'h0000, 8'h00, 2'b00, 4'h1);
    rdat(e);
    chk_level(e, status_o);
  endtask

  task automatic wcmd(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
                      input logic ok);
    xfer(OP_SET_LATCH, 16'h0000, 8'h00, 2'b00, 4'h0);
    ev_q.push_back(ok);
    xfer(op, a, d, (op == OP_STAT_WRITE) ? 2'b10 : 2'b11, 4'h0);
  endtask

  task automatic settle();
    for (int n = 0; n < 50; n++) begin
      xfer(OP_STAT_READ, 16'h0000, 8'h00, 2'b00, 4'h1);
      bus_rd(HR_RDATA, 32'h0000_0000, 32'h0000_0000);
      if (rdata_o[0] === 1'b0) return;
    end
    bad_count++;
    conclude();
  endtask

  function automatic logic prot(input logic [1:0] bp, input logic [12:0] a);
    return bp == 2'b11 || (bp == 2'b10 && a >= 13'h1000) || (bp == 2'b01 && a >= 13'h1800);
  endfunction

  initial begin
    logic [1:0] bp, rk;
    logic [15:0] a;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus_rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    bus_rd(HR_CTRL, 32'h0000_0008, 32'h0000_00FE);
    stat(8'h00);
    ev_q.push_back(1'b0);
    xfer(OP_STAT_WRITE, 16'h0000, 8'h8C, 2'b10, 4'h0);
    stat(8'h00);
    xfer(OP_SET_LATCH, 16'h0000, 8'h00, 2'b00, 4'h0);
    stat(8'h02);
    xfer(OP_CLR_LATCH, 16'h0000, 8'h00, 2'b00, 4'h0);
    stat(8'h00);
    xfer(OP_SET_LATCH, 16'h0000, 8'h00, 2'b00, 4'h0);
    xfer(8'hA5, 16'h0000, 8'h00, 2'b00, 4'h1);
    rdat(8'h00);
    stat(8'h02);
    // Each protect size once, in random order, then a write at a random address
    // One draw for the whole loop keeps the sizes a permutation
    rk = 2'($random(seed));
    for (int i = 0; i < 4; i++) begin
      bp = 2'(i) ^ rk;
      wcmd(OP_STAT_WRITE, 16'h0000, {4'h0, bp, 2'b00}, 1'b1);
      xfer(OP_STAT_READ, 16'h0000, 8'h00, 2'b00, 4'h2);
      rdat({4'h0, 2'(i ? bp ^ 2'(i) ^ 2'(i - 1) : 2'b00), 2'b11});
      settle();
      stat({4'h0, bp, 2'b00});
      a = 16'($random(seed));
      wcmd(OP_ARR_WRITE, a, 8'($random(seed)), !prot(bp, a[12:0]));
      settle();
      stat({4'h0, bp, prot(bp, a[12:0]), 1'b0});
    end
    wcmd(OP_STAT_WRITE, 16'h0000, 8'h80, 1'b1);
    settle();
    guard_lvl = 1'b0;
    wcmd(OP_STAT_WRITE, 16'h0000, 8'h0C, 1'b0);
    stat(8'h82);
    chk_level(8'h01, {7'h00, hw_lock_o});
    guard_lvl = 1'b1;
    ev_q.push_back(1'b1);
    xfer(OP_STAT_WRITE, 16'h0000, 8'h00, 2'b10, 4'h0);
    settle();
    stat(8'h00);
    chk_level(8'h00, {7'h00, hw_lock_o});
    xfer(OP_ARR_READ, 16'h0123, 8'h00, 2'b01, 4'h1);
    rdat(ERASED_BYTE);
    xfer(OP_ID_READ, 16'h0000, 8'h00, 2'b01, 4'h1);
    rdat(ERASED_BYTE);
    xfer(OP_ID_READ, LOCK_ADDR, 8'h00, 2'b01, 4'h1);
    rdat(8'h00);
    wcmd(OP_ID_WRITE, LOCK_ADDR, 8'h00, 1'b1);
    settle();
    xfer(OP_ID_READ, LOCK_ADDR, 8'h00, 2'b01, 4'h1);
    rdat(8'h01);
    chk_level(8'h01, {7'h00, id_locked_o});
    wcmd(OP_ID_WRITE, 16'h0005, 8'h5A, 1'b0);
    repeat (8) @(posedge clk_i);
    if (ev_q.size() != 0) begin
      bad_count++;
      $display("[FAIL] pending events expected 0 seen %0d", ev_q.size());
    end
    conclude();
  end
endmodule // spi_eeprom_instruction_status_tb

//--- hdl/see_device.sv
// EEPROM side: instruction decoder, status register and write-cycle timer
// Notes on behaviour
// R1: Commands are bytes, MSB first, opcode first.
// R2: Unknown opcode: ignore input until deselect.
// R3: Decode latch, status and array opcodes.
// R4: Shared ID opcodes split by following address.
// R5: Array address uses bits 12 to 0.
// R6: ID uses A4..A0; lock uses b10.
// R7: Writes need latch set by set command.
// R8: Latch commands act only at deselect.
// R9: Latch clears on reset, clear, write completion.
// R10: Status read repeats current status any time.
// R11: Master polls busy before next instruction.
// R12: Busy flag high exactly during write cycle.
// R13: Latch clear refuses writes and status writes.
// R14: Protect bits nonvolatile, status write only.
// R15: Lock bit plus low guard blocks status write.
// R16: Status byte: lock,000,hi,lo,latch,busy.
// R17: Protect sizes: none, quarter, half, all.
// R18: Execute only on deselect at exact bit.
// R19: Writes need clock count multiple of eight.
// R20: Sample on rise, shift out after fall.
// R21: Data out released unless returning data.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
module see_device #(
  parameter int unsigned WRITE_CYCLES = see_pkg::WRITE_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  see_spi_if.device spi,
  output logic [7:0] status_o,
  output logic hw_lock_o,
  output logic id_locked_o,
  output logic write_start_o,
  output logic refused_o
);
  import see_pkg::*;

  typedef enum logic [2:0] {
    SD_OPC,
    SD_ADDR,
    SD_DATA,
    SD_STAT,
    SD_READ,
    SD_HOLD
  } see_dev_state_e;

  see_dev_state_e state_q;
  logic [3:0] sync1_q, sync2_q;
  logic [1:0] prev_q;
  logic armed_q, selected_q;
  logic [7:0] cmd_q, sh_q, sr_new_q, tx_sh_q;
  logic [15:0] addr_q;
  logic [2:0] bcnt_q, nbytes_q, tx_cnt_q;
  logic miso_q, busy_q, latch_q, id_lock_q, pend_sr_q, pend_lock_q;
  logic [2:0] nv_q;
  logic [19:0] wcnt_q;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, deselect, exec;
  logic [7:0] rx_byte, status_w, tx_src;
  logic hw_lock, tx_on, wr_done, wr_try, go_sr, go_arr, go_idw, go_lock, go_any;

  // Write-protected region test
  function automatic logic is_protected(input logic [2:0] nv, input logic [15:0] a);
    logic [15:0] m;
    m = a & ARR_ADDR_MASK; // [R5]
    case (nv[1:0]) // [R17]
      2'b01: is_protected = (m >= PROT_QUARTER_BASE);
      2'b10: is_protected = (m >= PROT_HALF_BASE);
      2'b11: is_protected = 1'b1;
      default: is_protected = 1'b0;
    endcase
  endfunction

  // Next state after the opcode byte
  function automatic see_dev_state_e decode(input logic [7:0] op);
    case (op)
      OP_STAT_READ: decode = SD_STAT;
      OP_STAT_WRITE: decode = SD_DATA;
      OP_ARR_READ, OP_ARR_WRITE, OP_ID_READ, OP_ID_WRITE: decode = SD_ADDR;
      default: decode = SD_HOLD; // [R2] [R8]
    endcase
  endfunction

  // Pins cross into clk_i through two flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 4'hB;
      sync2_q <= 4'hB;
      prev_q <= 2'h3;
    end else begin
      sync1_q <= {spi.guard_n, spi.mosi, spi.cs_n, spi.sclk};
      sync2_q <= sync1_q;
      prev_q <= sync2_q[1:0];
    end
  end

  assign sclk_rise = sync2_q[0] & ~prev_q[0];
  assign sclk_fall = ~sync2_q[0] & prev_q[0];
  assign cs_fall = ~sync2_q[1] & prev_q[1];
  assign cs_rise = sync2_q[1] & ~prev_q[1];
  assign deselect = cs_rise & selected_q;
  assign rx_byte = {sh_q[6:0], sync2_q[2]};
  assign hw_lock = nv_q[2] & ~sync2_q[3]; // [R15]

  // Select only after select has been seen high since reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
      selected_q <= 1'b0;
    end else begin
      if (sync2_q[1]) begin
        armed_q <= 1'b1;
      end
      if (cs_rise) begin
        selected_q <= 1'b0;
      end else if (cs_fall && armed_q) begin
        selected_q <= 1'b1;
      end
    end
  end

  // Command receiver
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SD_OPC;
      cmd_q <= OP_NONE;
      sh_q <= 8'h00;
      addr_q <= 16'h0000;
      sr_new_q <= 8'h00;
      bcnt_q <= 3'h0;
      nbytes_q <= 3'h0;
    end else if (!selected_q) begin
      state_q <= SD_OPC;
      bcnt_q <= 3'h0;
      nbytes_q <= 3'h0;
    end else if (sclk_rise) begin
      sh_q <= rx_byte; // [R20]
      bcnt_q <= bcnt_q + 3'h1;
      if (bcnt_q == 3'h7) begin
        if (nbytes_q != 3'h7) begin
          nbytes_q <= nbytes_q + 3'h1;
        end
        case (state_q)
          SD_OPC: begin
            // Only status read is taken while a write cycle runs
            if (busy_q && rx_byte != OP_STAT_READ) begin
              cmd_q <= OP_NONE;
              state_q <= SD_HOLD;
            end else begin
              cmd_q <= rx_byte; // [R1] [R3] [R4]
              state_q <= decode(rx_byte);
            end
          end
          SD_ADDR: begin
            addr_q <= {addr_q[7:0], rx_byte}; // [R5] [R6]
            if (nbytes_q == 3'h2) begin
              state_q <= (cmd_q == OP_ARR_READ || cmd_q == OP_ID_READ) ? SD_READ : SD_DATA;
            end
          end
          SD_DATA: begin
            if (nbytes_q == 3'h1) begin
              sr_new_q <= rx_byte;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign status_w = {nv_q[2], 3'h0, nv_q[1], nv_q[0], latch_q, busy_q}; // [R16]

  // ID reads of the lock address return the lock state; no array storage here
  always_comb begin
    tx_src = ERASED_BYTE;
    if (state_q == SD_STAT) begin
      tx_src = status_w; // [R10]
    end else if (cmd_q == OP_ID_READ && addr_q == LOCK_ADDR) begin
      tx_src = {7'h00, id_lock_q}; // [R4] [R6]
    end
  end

  assign tx_on = selected_q & (state_q == SD_STAT || state_q == SD_READ);

  // Transmitter: a fresh byte is fetched every eight falling edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cnt_q <= 3'h0;
      tx_sh_q <= 8'h00;
      miso_q <= 1'b0;
    end else if (!tx_on) begin
      tx_cnt_q <= 3'h0;
      miso_q <= 1'b0;
    end else if (sclk_fall) begin
      tx_cnt_q <= tx_cnt_q + 3'h1; // [R20]
      if (tx_cnt_q == 3'h0) begin
        miso_q <= tx_src[7];
        tx_sh_q <= {tx_src[6:0], 1'b0};
      end else begin
        miso_q <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  assign spi.miso = miso_q;
  assign spi.miso_oe = tx_on; // [R21]

  // Deselect exactly on a byte boundary triggers execution
  assign exec = deselect & (bcnt_q == 3'h0); // [R18] [R19]
  assign wr_try = exec & (state_q == SD_DATA);
  assign go_sr = wr_try & (cmd_q == OP_STAT_WRITE) & (nbytes_q == 3'h2)
               & latch_q & ~hw_lock; // [R7] [R13] [R15]
  assign go_arr = wr_try & (cmd_q == OP_ARR_WRITE) & (nbytes_q >= 3'h4)
                & latch_q & ~is_protected(nv_q, addr_q); // [R13] [R17]
  assign go_idw = wr_try & (cmd_q == OP_ID_WRITE) & (nbytes_q >= 3'h4) & latch_q
                & ~id_lock_q & ((addr_q & ID_ADDR_MASK) == 16'h0000); // [R6]
  assign go_lock = wr_try & (cmd_q == OP_ID_WRITE) & (nbytes_q >= 3'h4) & latch_q
                 & ~id_lock_q & (addr_q == LOCK_ADDR); // [R4]
  assign go_any = go_sr | go_arr | go_idw | go_lock;
  assign wr_done = busy_q & (wcnt_q == 20'h0_0000);

  // Self-timed write cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      wcnt_q <= 20'h0_0000;
      pend_sr_q <= 1'b0;
      pend_lock_q <= 1'b0;
    end else if (go_any) begin
      busy_q <= 1'b1; // [R12]
      wcnt_q <= 20'(WRITE_CYCLES - 1);
      pend_sr_q <= go_sr;
      pend_lock_q <= go_lock;
    end else if (wr_done) begin
      busy_q <= 1'b0; // [R12]
      pend_sr_q <= 1'b0;
      pend_lock_q <= 1'b0;
    end else if (busy_q) begin
      wcnt_q <= wcnt_q - 20'h0_0001;
    end
  end

  // Write latch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= 1'b0; // [R9]
    end else if (wr_done || (exec && cmd_q == OP_CLR_LATCH && nbytes_q == 3'h1)) begin
      latch_q <= 1'b0; // [R8] [R9]
    end else if (exec && cmd_q == OP_SET_LATCH && nbytes_q == 3'h1) begin
      latch_q <= 1'b1; // [R7] [R8]
    end
  end

  // Nonvolatile bits change only when a status write or lock write cycle completes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nv_q <= NV_RESET;
      id_lock_q <= 1'b0;
    end else if (wr_done) begin
      if (pend_sr_q) begin
        nv_q <= {sr_new_q[ST_LOCK_BIT], sr_new_q[ST_PS_HI_BIT], sr_new_q[ST_PS_LO_BIT]}; // [R14]
      end
      if (pend_lock_q) begin
        id_lock_q <= 1'b1;
      end
    end
  end

  assign status_o = status_w;
  assign hw_lock_o = hw_lock;
  assign id_locked_o = id_lock_q;
  assign write_start_o = go_any;
  assign refused_o = wr_try & ~go_any;

endmodule // see_device

//--- hdl/see_host.sv
// SPI master end: register-driven command sequencer for the EEPROM
module see_host (
  input wire logic clk_i,
  input wire logic rst_i,
  see_spi_if.host spi,
  input wire logic [see_pkg::HR_AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  import see_pkg::*;

  typedef enum logic [2:0] {
    SH_IDLE,
    SH_LEAD,
    SH_LOW,
    SH_HIGH,
    SH_TAIL,
    SH_GAP
  } see_host_state_e;

  see_host_state_e state_q;
  logic [7:0] opcode_q, wdata_q, ctrl_q, rx_q;
  logic [15:0] addr_q;
  logic [31:0] tx_q, rdata_q;
  logic [7:0] bits_q;
  logic [3:0] div_q;
  logic sclk_q, cs_n_q, miso1_q, miso2_q, go;
  logic half_done;
  logic [7:0] nbits;
  logic [31:0] tx_init;

  assign go = wr_i && addr_i == HR_CTRL && wdata_i[CTRL_GO_BIT] && state_q == SH_IDLE;
  assign half_done = (div_q == 4'(SCLK_HALF - 1));

  // Frame length and payload, opcode first and MSB first
  always_comb begin
    nbits = 8'h08 + {1'b0, wdata_i[CTRL_RLEN_LSB+3:CTRL_RLEN_LSB], 3'h0};
    tx_init = {opcode_q, 24'h00_0000};
    if (wdata_i[CTRL_ADDR_BIT] && wdata_i[CTRL_DATA_BIT]) begin
      tx_init = {opcode_q, addr_q, wdata_q};
      nbits = nbits + 8'h18;
    end else if (wdata_i[CTRL_ADDR_BIT]) begin
      tx_init = {opcode_q, addr_q, 8'h00};
      nbits = nbits + 8'h10;
    end else if (wdata_i[CTRL_DATA_BIT]) begin
      tx_init = {opcode_q, wdata_q, 16'h0000};
      nbits = nbits + 8'h08;
    end
  end

  // Software registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      opcode_q <= 8'h00;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      ctrl_q <= CTRL_RESET;
    end else if (wr_i) begin
      case (addr_i)
        HR_OPCODE: opcode_q <= wdata_i[7:0];
        HR_ADDR: addr_q <= wdata_i[15:0];
        HR_WDATA: wdata_q <= wdata_i[7:0];
        HR_CTRL: begin
          // Guard pin level may change any time; frame bits only when idle
          ctrl_q[CTRL_GUARD_BIT] <= wdata_i[CTRL_GUARD_BIT];
          if (state_q == SH_IDLE) begin
            ctrl_q <= {wdata_i[7:1], 1'b0};
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        HR_OPCODE: rdata_q <= {24'h00_0000, opcode_q};
        HR_ADDR: rdata_q <= {16'h0000, addr_q};
        HR_WDATA: rdata_q <= {24'h00_0000, wdata_q};
        HR_CTRL: rdata_q <= {24'h00_0000, ctrl_q};
        HR_STATUS: rdata_q <= {31'h0000_0000, state_q != SH_IDLE};
        HR_RDATA: rdata_q <= {24'h00_0000, rx_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign rdata_o = rdata_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      miso1_q <= 1'b0;
      miso2_q <= 1'b0;
    end else begin
      miso1_q <= spi.miso_line;
      miso2_q <= miso1_q;
    end
  end

  // Mode 0 frame sequencer; sclk is clk_i divided by 2*SCLK_HALF
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SH_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      tx_q <= 32'h0000_0000;
      rx_q <= 8'h00;
      bits_q <= 8'h00;
      div_q <= 4'h0;
    end else begin
      div_q <= half_done ? 4'h0 : div_q + 4'h1;
      case (state_q)
        SH_IDLE: begin
          div_q <= 4'h0;
          if (go) begin
            tx_q <= tx_init; // [R1]
            bits_q <= nbits;
            cs_n_q <= 1'b0;
            state_q <= SH_LEAD;
          end
        end
        SH_LEAD: begin
          // Raise the clock here so the first high phase is a full half period
          if (half_done) begin
            sclk_q <= 1'b1; // [R20]
            state_q <= SH_HIGH;
          end
        end
        SH_LOW: begin
          if (half_done) begin
            sclk_q <= 1'b1; // [R20]
            state_q <= SH_HIGH;
          end
        end
        SH_HIGH: begin
          sclk_q <= 1'b1;
          if (half_done) begin
            // Sample late in the high phase: the slave drives after the fall
            rx_q <= {rx_q[6:0], miso2_q}; // [R20]
            sclk_q <= 1'b0;
            bits_q <= bits_q - 8'h01;
            if (bits_q == 8'h01) begin
              state_q <= SH_TAIL;
            end else begin
              tx_q <= {tx_q[30:0], 1'b0};
              state_q <= SH_LOW;
            end
          end
        end
        SH_TAIL: begin
          if (half_done) begin
            cs_n_q <= 1'b1; // [R18]
            state_q <= SH_GAP;
          end
        end
        SH_GAP: if (half_done) state_q <= SH_IDLE;
        default: state_q <= SH_IDLE;
      endcase
    end
  end

  assign spi.sclk = sclk_q;
  assign spi.cs_n = cs_n_q;
  assign spi.mosi = tx_q[31];
  assign spi.guard_n = ctrl_q[CTRL_GUARD_BIT];

endmodule // see_host

//--- hdl/see_pkg.sv
// Shared constants for the serial EEPROM command interpreter and its SPI master
package see_pkg;

  // Instruction opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_READ = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [7:0] OP_ARR_READ = 8'h03;
  localparam logic [7:0] OP_ARR_WRITE = 8'h02;
  localparam logic [7:0] OP_ID_READ = 8'h83;
  localparam logic [7:0] OP_ID_WRITE = 8'h82;
  // Not a defined opcode; reset value, and marks a command refused during a write cycle
  localparam logic [7:0] OP_NONE = 8'h00;

  // Status byte layout
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_LATCH_BIT = 1;
  localparam int unsigned ST_PS_LO_BIT = 2;
  localparam int unsigned ST_PS_HI_BIT = 3;
  localparam int unsigned ST_LOCK_BIT = 7;
  // Nonvolatile bits {status_lock_bit, protect_size_hi, protect_size_lo}
  localparam logic [2:0] NV_RESET = 3'h0;

  // Addressing
  localparam logic [15:0] ARR_ADDR_MASK = 16'h1FFF;
  localparam logic [15:0] ID_ADDR_MASK = 16'hFFE0;
  localparam logic [15:0] LOCK_ADDR = 16'h0400;
  localparam logic [15:0] PROT_QUARTER_BASE = 16'h1800;
  localparam logic [15:0] PROT_HALF_BASE = 16'h1000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CLK_FREQ_MHZ = 20;
  localparam int unsigned WRITE_TIME_US = 4000;
  localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned SCLK_PERIOD_NS = 400;
  localparam int unsigned SCLK_HALF = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Host controller register map
  localparam int unsigned HR_AW = 8;
  localparam logic [7:0] HR_OPCODE = 8'h00;
  localparam logic [7:0] HR_ADDR = 8'h04;
  localparam logic [7:0] HR_WDATA = 8'h08;
  localparam logic [7:0] HR_CTRL = 8'h0C;
  localparam logic [7:0] HR_STATUS = 8'h10;
  localparam logic [7:0] HR_RDATA = 8'h14;
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_ADDR_BIT = 1;
  localparam int unsigned CTRL_DATA_BIT = 2;
  localparam int unsigned CTRL_GUARD_BIT = 3;
  localparam int unsigned CTRL_RLEN_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h08;

endpackage

//--- hdl/see_spi_if.sv
// SPI link between the EEPROM command interpreter and its master
interface see_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic guard_n;
  // Resolved data-out wire; undriven reads low
  logic miso_line;

  assign miso_line = miso_oe & miso;

  modport device (
    input sclk,
    input cs_n,
    input mosi,
    input guard_n,
    output miso,
    output miso_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    output guard_n,
    input miso_line
  );
endinterface
